// file: rhd_map.vh
// Purpose: constants for the root hub descriptor A register block
// Assumes: 250 MHz clock, AHB-Lite register access, 32-bit data
// Notes: all offsets are byte addresses
// How it works
// R1 - the power-good delay field counts 2 ms steps that pass before port power counts as stable.
// R2 - only bits 25 and 24 of the power-good delay field are stored and its other bits read zero.
// R3 - software always writes a non-zero power-good delay, normally one, adjusted only a little.
// R4 - bit 12 set stops over-current reporting and bit 12 clear lets it be reported.
// R5 - bit 11 picks global (0) or per-port (1) over-current and counts only while bit 12 is clear.
// R6 - software writes zero to bit 11 so one global over-current indication serves all ports.
// R7 - bit 10 is read-only zero, telling that the root hub is not a compound device.
// R8 - bit 9 clear means ports are power switched and bit 9 set means they are always powered.
// R9 - the read-only low byte returns three, the number of downstream ports.
// R10 - reset loads the register with 01000003h, one delay unit and three ports.
// R11 - only the power-on reset clears the register and any other reset leaves it alone.
// R12 - writes to bits 23 to 13 are ignored and those bits read zero.
`ifndef RHD_MAP_VH
`define RHD_MAP_VH
`define RHD_DESC_A_OFFS   8'h48
`define RHD_RESET_VAL     32'h01000003
`define RHD_PGD_RESET     2'h1
`define RHD_PGD_HI        25
`define RHD_PGD_LO        24
`define RHD_OC_DIS_BIT    12
`define RHD_OC_PORT_BIT   11
`define RHD_COMPOUND_BIT  10
`define RHD_ALWAYS_PWR_BIT 9
`define RHD_PORT_COUNT    8'h03
`define RHD_CLK_PERIOD_NS 4
`define RHD_UNIT_TIME_NS  2000000
`define RHD_UNIT_CYCLES   (`RHD_UNIT_TIME_NS / `RHD_CLK_PERIOD_NS)
`endif

// file: rhd_pgood_timer.v
// Purpose: counts power-good delay units after port power comes on
// Assumes: start is a one-cycle pulse, units stable while counting
// Notes: zero units gives good on the next edge
`timescale 1ns/1ps
module rhd_pgood_timer #(
   parameter UNIT_CYCLES = 500000,
   parameter CW          = 20
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire       clear,
   input  wire       start,
   input  wire [1:0] units,
   output reg        good_q
);
   reg [CW-1:0] cyc_q;
   reg [1:0]    left_q;
   reg          run_q;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cyc_q  <= {CW{1'b0}};
         left_q <= 2'h0;
         run_q  <= 1'b0;
         good_q <= 1'b0;
      end else if (clear) begin
         cyc_q  <= {CW{1'b0}};
         left_q <= 2'h0;
         run_q  <= 1'b0;
         good_q <= 1'b0;
      end else if (start) begin
         cyc_q  <= {CW{1'b0}};
         left_q <= units;
         run_q  <= (units != 2'h0);
         good_q <= (units == 2'h0);
      end else if (run_q) begin
         // one unit elapses per UNIT_CYCLES clocks [R1]
         if (cyc_q == UNIT_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
            cyc_q <= {CW{1'b0}};
            if (left_q == 2'h1) begin
               run_q  <= 1'b0;
               good_q <= 1'b1;
            end
            left_q <= left_q - 2'h1;
         end else begin
            cyc_q <= cyc_q + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // rhd_pgood_timer

// file: rhd_top.v
// Purpose: root hub descriptor A register with AHB-Lite slave and its control outputs
// Assumes: nrst is the power-on reset, host_rst is any other reset
// Notes: zero wait states, response always OKAY
`timescale 1ns/1ps
`include "rhd_map.vh"
module rhd_top #(
   parameter UNIT_CYCLES = `RHD_UNIT_CYCLES,
   parameter PORTS       = 3
) (
   input  wire             clk,
   input  wire             nrst,
   input  wire             host_rst,
   input  wire             hsel,
   input  wire [31:0]      haddr,
   input  wire [1:0]       htrans,
   input  wire             hwrite,
   input  wire [2:0]       hsize,
   input  wire [31:0]      hwdata,
   input  wire             hready,
   output reg  [31:0]      hrdata,
   output reg              hreadyout,
   output reg              hresp,
   input  wire             port_power_req,
   input  wire             overcurrent_in,
   input  wire [PORTS-1:0] overcurrent_port_in,
   output reg  [1:0]       power_good_delay,
   output reg              overcurrent_report_disable,
   output reg              overcurrent_per_port_select,
   output reg              port_always_powered,
   output reg              port_power_en,
   output reg              port_power_good,
   output reg              overcurrent_global,
   output reg  [PORTS-1:0] overcurrent_port
);
   reg  [1:0]  pgd_q;
   reg         ocdis_q;
   reg         ocport_q;
   reg         nps_q;
   reg         wr_pend_q;
   reg         pwr_q;
   reg  [1:0]  pgd_d;
   reg         ocdis_d;
   reg         ocport_d;
   reg         nps_d;
   reg  [31:0] rd_val;
   wire        acc;
   wire        hit;
   wire        pwr_d;
   wire        good;

   assign acc = hsel & htrans[1] & hready;
   assign hit = (haddr[7:0] == `RHD_DESC_A_OFFS) & (haddr[31:8] == 24'h000000);

   // write data lands in the data phase; reserved and read-only bits dropped
   always @* begin
      pgd_d    = pgd_q;
      ocdis_d  = ocdis_q;
      ocport_d = ocport_q;
      nps_d    = nps_q;
      if (wr_pend_q) begin
         pgd_d    = hwdata[`RHD_PGD_HI:`RHD_PGD_LO]; // [R2] [R12]
         ocdis_d  = hwdata[`RHD_OC_DIS_BIT];
         ocport_d = hwdata[`RHD_OC_PORT_BIT];
         nps_d    = hwdata[`RHD_ALWAYS_PWR_BIT];
      end
   end

   // read image built from the next value so a read right after a write sees it
   always @* begin
      rd_val = 32'h00000000; // [R12]
      rd_val[`RHD_PGD_HI:`RHD_PGD_LO] = pgd_d; // [R2]
      rd_val[`RHD_OC_DIS_BIT]        = ocdis_d;
      rd_val[`RHD_OC_PORT_BIT]       = ocport_d;
      rd_val[`RHD_COMPOUND_BIT]      = 1'b0; // [R7]
      rd_val[`RHD_ALWAYS_PWR_BIT]    = nps_d;
      rd_val[7:0]                    = `RHD_PORT_COUNT; // [R9]
   end

   // register state, cleared by power-on reset only
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pgd_q    <= `RHD_PGD_RESET; // [R10] [R11]
         ocdis_q  <= 1'b0;
         ocport_q <= 1'b0;
         nps_q    <= 1'b0;
      end else begin
         pgd_q    <= pgd_d;
         ocdis_q  <= ocdis_d;
         ocport_q <= ocport_d;
         nps_q    <= nps_d;
      end
   end

   // bus pipeline, cleared also by the host reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (host_rst) begin
         wr_pend_q <= 1'b0;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= acc & hwrite & hit & (hsize == 3'h2);
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc & ~hwrite & hit) begin
            hrdata <= rd_val;
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   // port power follows the request unless always powered [R8]
   assign pwr_d = nps_q | port_power_req;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= 1'b0;
      end else if (host_rst) begin
         pwr_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   rhd_pgood_timer #(
      .UNIT_CYCLES (UNIT_CYCLES),
      .CW          (20)
   ) u_timer (
      .clk    (clk),
      .nrst   (nrst),
      .clear  (host_rst | ~pwr_d),
      .start  (pwr_d & ~pwr_q),
      .units  (pgd_q),
      .good_q (good)
   );

   // outputs, all from flip-flops
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_good_delay            <= `RHD_PGD_RESET;
         overcurrent_report_disable  <= 1'b0;
         overcurrent_per_port_select <= 1'b0;
         port_always_powered         <= 1'b0;
         port_power_en               <= 1'b0;
         port_power_good             <= 1'b0;
         overcurrent_global          <= 1'b0;
         overcurrent_port            <= {PORTS{1'b0}};
      end else begin
         power_good_delay            <= pgd_q;
         overcurrent_report_disable  <= ocdis_q;
         overcurrent_per_port_select <= ocport_q;
         port_always_powered         <= nps_q;
         port_power_en               <= pwr_q; // [R8]
         port_power_good             <= good & pwr_q; // [R1]
         // reporting gated by disable, mode valid only when enabled [R4] [R5]
         overcurrent_global <= ~ocdis_q & ~ocport_q & overcurrent_in;
         if (ocdis_q) begin
            overcurrent_port <= {PORTS{1'b0}};
         end else if (ocport_q) begin
            overcurrent_port <= overcurrent_port_in;
         end else begin
            overcurrent_port <= {PORTS{overcurrent_in}};
         end
      end
   end
endmodule // rhd_top

// file: rhd_top_assertions.sv
// Purpose: port checker for rhd_top
// Assumes: register at byte address 0x48
// Notes: bound after the module
`timescale 1ns/1ps
module rhd_top_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        host_rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        overcurrent_report_disable,
   input wire logic        overcurrent_per_port_select,
   input wire logic        port_always_powered,
   input wire logic        port_power_en,
   input wire logic        overcurrent_global
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire acc = hsel && htrans[1] && hready && !host_rst && haddr == 32'h00000048;
   wire rd  = acc && !hwrite;
   wire wr  = acc && hwrite;
   property wr_mirror_p;
      logic [31:0] d;
      (wr ##1 (1'b1, d = hwdata)) |-> ##[1:2] (port_always_powered == d[9] &&
         overcurrent_report_disable == d[12] && overcurrent_per_port_select == d[11]);
   endproperty
   port_count_a: assert property (rd |=> hrdata[7:0] == 8'h03) else $error("port count");
   reserved_zero_a: assert property (rd |=> hrdata[23:13] == 11'h000) else $error("rsvd");
   compound_zero_a: assert property (rd |=> !hrdata[10]) else $error("compound bit");
   delay_high_a: assert property (rd |=> hrdata[31:26] == 6'h00) else $error("delay hi");
   field_mirror_a: assert property (wr_mirror_p) else $error("field copy");
   oc_disable_a: assert property (overcurrent_report_disable [*3] |-> !overcurrent_global)
      else $error("oc disable");
   oc_mode_a: assert property ((overcurrent_per_port_select && !overcurrent_report_disable) [*3]
      |-> !overcurrent_global) else $error("oc mode");
   always_power_a: assert property ((port_always_powered && !host_rst) [*3] |-> port_power_en)
      else $error("always powered");
   cover property (wr);
   cover property (rd);
   cover property (overcurrent_global);
endmodule // rhd_top_chk
bind rhd_top rhd_top_chk u_rhd_top_chk (
   .clk                         (clk),
   .nrst                        (nrst),
   .host_rst                    (host_rst),
   .hsel                        (hsel),
   .haddr                       (haddr),
   .htrans                      (htrans),
   .hwrite                      (hwrite),
   .hwdata                      (hwdata),
   .hready                      (hready),
   .hrdata                      (hrdata),
   .overcurrent_report_disable  (overcurrent_report_disable),
   .overcurrent_per_port_select (overcurrent_per_port_select),
   .port_always_powered         (port_always_powered),
   .port_power_en               (port_power_en),
   .overcurrent_global          (overcurrent_global)
);

// file: rhd_top_tb_top.sv
// Purpose: self-checking bench for rhd_top
// Assumes: zero wait AHB-Lite slave, UNIT_CYCLES 8
// Notes: reads checked from a queue at the falling edge
`timescale 1ns/1ps
module rhd_top_tb_top;
   logic        clk = 0, nrst = 0, host_rst = 0, hwrite = 0, req = 0, oc = 0, ph = 0;
   logic        hresp, ocd, ocps, pap, ppe, ppg, ocg;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
   logic [1:0]  htrans = 0, pgd;
   logic [2:0]  ocp_in = 0, ocp;
   wire         hready;
   integer      n_errors = 0, compares = 0, seed = 39220, i;
   logic [31:0] q[$];
   always #2 clk = ~clk;
   rhd_top #(.UNIT_CYCLES(8)) u_rhd_top (.clk(clk), .nrst(nrst), .host_rst(host_rst),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .port_power_req(req), .overcurrent_in(oc), .overcurrent_port_in(ocp_in),
      .power_good_delay(pgd), .overcurrent_report_disable(ocd),
      .overcurrent_per_port_select(ocps), .port_always_powered(pap), .port_power_en(ppe),
      .port_power_good(ppg), .overcurrent_global(ocg), .overcurrent_port(ocp));
   task chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task results;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task xfer(input logic w, input logic [31:0] a, dw, e);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= dw;
      if (!w) q.push_back(e);
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
   endtask
   task cfg(input logic [31:0] v);
      xfer(1, 32'h48, v, 0);
      repeat (4) @(posedge clk);
   endtask
   always @(posedge clk) ph <= htrans[1] && hready && !hwrite;
   always @(negedge clk) if (ph && q.size() > 0) chk("hrdata", hrdata, q.pop_front());
   initial begin
      #8000;
      n_errors++;
      results;
   end
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      xfer(0, 32'h48, 0, 32'h01000003);
      chk("pgd", {30'h0, pgd}, 1);
      xfer(1, 32'h48, 32'hFFFFFFFF, 0);
      xfer(0, 32'h48, 0, 32'h03001A03);
      for (i = 0; i < 6; i++) begin
         d = $random(seed) | 32'h01000000;
         xfer(1, 32'h48, d, 0);
         xfer(0, 32'h48, 0, d & 32'h03001A00 | 32'h3);
      end
      xfer(1, 32'h4C, 32'hFFFFFFFF, 0);
      xfer(0, 32'h4C, 0, 0);
      $display("test register done");
      host_rst <= 1;
      @(posedge clk);
      host_rst <= 0;
      xfer(0, 32'h48, 0, d & 32'h03001A00 | 32'h3);
      nrst <= 0;
      @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      xfer(0, 32'h48, 0, 32'h01000003);
      $display("test reset done");
      oc <= 1;
      ocp_in <= 3'h5;
      cfg(32'h01000000);
      chk("ocg", ocg, 1);
      chk("ocp", ocp, 3'h7);
      cfg(32'h01000800);
      chk("ocg", ocg, 0);
      chk("ocp", ocp, 3'h5);
      cfg(32'h01001800);
      chk("ocp", ocp, 0);
      chk("ocg", ocg, 0);
      chk("ocd", ocd, 1);
      chk("ocps", ocps, 1);
      $display("test overcurrent done");
      cfg(32'h02000000);
      chk("pgd", pgd, 2);
      req <= 1;
      repeat (17) @(posedge clk);
      @(negedge clk);
      chk("ppg", ppg, 0);
      chk("ppe", ppe, 1);
      @(posedge clk);
      @(negedge clk);
      chk("ppg", ppg, 1);
      @(posedge clk);
      req <= 0;
      cfg(32'h01000200);
      chk("ppe", ppe, 1);
      chk("pap", pap, 1);
      chk("hresp", hresp, 0);
      $display("test power done");
      results;
   end
endmodule // rhd_top_tb_top
